/* File: common/port_timer_pkg.sv */
// package: register map, field layouts and reset values of the output port / timer block
// assumes one 8-bit register per aligned 32-bit APB word
package port_timer_pkg;
   // printed offsets are not all multiples of four: these are register indexes, byte address = 4 * index
   localparam logic [6:0] IDX_TIMER_UPPER = 7'h06;
   localparam logic [6:0] IDX_TIMER_LOWER = 7'h07;
   localparam logic [6:0] IDX_VECTOR = 7'h0C;
   localparam logic [6:0] IDX_INPUT_ROUTING = 7'h0D;
   localparam logic [6:0] IDX_START_SET = 7'h0E;
   localparam logic [6:0] IDX_STOP_CLEAR = 7'h0F;
   // own registers for the control bits the map does not hold
   localparam logic [6:0] IDX_TIMER_MODE = 7'h40;
   localparam logic [6:0] IDX_LATCH_READ = 7'h41;
   localparam logic [6:0] IDX_STATUS = 7'h42;
   localparam logic [6:0] IDX_PIN_MODE = 7'h43;
   localparam int ADDR_W = 9;
   localparam logic [7:0] VECTOR_RESET = 8'h0F;
   localparam logic [7:0] ROUTING_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [15:0] PRESET_RESET = 16'h0000;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
   localparam logic [3:0] CLK_SEL_ONE_X = 4'hF;
   // routing field positions
   localparam int RT_IO3_LO = 2;
   localparam int RT_IO2_LO = 0;
   // pin-mode register bits
   localparam int PM_RTS_A = 0;
   localparam int PM_RTS_B = 1;
   localparam int PM_TIMEOUT = 2;
   localparam int PM_TIMER = 3;
   // interrupt status bit positions
   localparam int IS_TX_A = 0;
   localparam int IS_RX_A = 1;
   localparam int IS_TX_B = 4;
   localparam int IS_RX_B = 5;

   typedef enum logic [1:0] {
      SEL_LATCH = 2'b00,
      SEL_ONE = 2'b01,
      SEL_TWO = 2'b10,
      SEL_THREE = 2'b11
   } route_sel_e;

   typedef struct packed {
      logic chan_a_tx_clock_16x;
      logic chan_a_tx_clock;
      logic chan_a_rx_clock;
      logic chan_b_tx_clock;
      logic chan_b_rx_clock;
   } uart_clocks_s;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
   } pin_drive_s;
endpackage : port_timer_pkg

/* File: sim/output_port_and_timer_regs_bench.sv */
// bench: apb master, pin and timer checks for the port block
// assumes the uart pin model and the bound checker
`timescale 1ns/1ps
module output_port_and_timer_regs_bench import port_timer_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, counter_ready, count_tick, c2, c3;
   logic chan_a_request_to_send, chan_b_request_to_send;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb, chan_a_clock_select;
   logic [6:0] chan_a_port_levels;
   logic [7:0] interrupt_status, ex, d, s;
   logic [9:0] e;
   logic [9:0] exq[$];
   uart_clocks_s uart_clocks;
   pin_drive_s pins;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   uart_pin_model far_u (.pclk(pclk), .presetn(presetn), .uart_clocks(uart_clocks));
   output_port_and_timer_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chan_a_port_levels(chan_a_port_levels), .interrupt_status(interrupt_status),
      .chan_a_clock_select(chan_a_clock_select), .chan_a_request_to_send(chan_a_request_to_send),
      .chan_b_request_to_send(chan_b_request_to_send), .uart_clocks(uart_clocks), .count_tick(count_tick),
      .pins(pins), .counter_ready(counter_ready));
   ////////////////////////////////////////
   task automatic chk(input string n, input logic [8:0] seen, input logic [8:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   task automatic results();
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results
   // e: bit 9 skips the compare, bit 8 the error flag, 7:0 the data
   task automatic xfer(input logic w, input logic [6:0] i, input logic [7:0] dv, input logic [9:0] ev);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {i, 2'h0};
      pwdata <= {24'h000000, dv};
      if (!w) exq.push_back(ev);
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : xfer
   task automatic wr(input logic [6:0] i, input logic [7:0] dv);
      xfer(1'h1, i, dv, 10'h200);
   endtask : wr
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge pclk);
         count_tick <= 1'h1;
         @(posedge pclk);
         count_tick <= 1'h0;
      end
   endtask : tick
   function automatic logic lv(input int i);
      return pins.oe_n[i] ? 1'h1 : pins.out[i];
   endfunction : lv
   ////////////////////////////////////////
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         results();
      end
      if (psel && penable && pready && !pwrite) begin
         e = exq.pop_front();
         if (!e[9]) chk("read data", {pslverr, prdata[7:0]}, e[8:0]);
      end
   end
   initial begin
      pclk = 1'h0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, count_tick, chan_a_request_to_send, chan_b_request_to_send} = 7'h00;
      {paddr, pwdata, pstrb, chan_a_clock_select} = {9'h000, 32'h00000000, 4'hF, 4'h0};
      {chan_a_port_levels, interrupt_status, ex} = {7'h00, 8'h00, 8'h00};
      d = $urandom(16443);
      @(posedge pclk);
      @(negedge pclk);
      chk("reset pins", {counter_ready, pins.out}, 9'h0FF);
      @(posedge pclk);
      presetn <= 1'h1;
      xfer(1'h0, IDX_VECTOR, 8'h00, {2'h0, VECTOR_RESET});
      d = $urandom;
      wr(IDX_VECTOR, d);
      xfer(1'h0, IDX_VECTOR, 8'h00, {2'h0, d});
      chan_a_port_levels <= d[6:0];
      xfer(1'h0, IDX_INPUT_ROUTING, 8'h00, {3'h1, d[6:0]});
      xfer(1'h0, 7'h1E, 8'h00, 10'h100);
      repeat (4) begin
         d = $urandom;
         s = $urandom;
         wr(IDX_START_SET, d);
         wr(IDX_STOP_CLEAR, s);
         ex = (ex | d) & ~s;
         xfer(1'h0, IDX_LATCH_READ, 8'h00, {2'h0, ex});
         @(negedge pclk);
         chk("latch pins", {|pins.oe_n, pins.out}, {1'h0, ~ex});
      end
      wr(IDX_INPUT_ROUTING, 8'hF0);
      wr(IDX_PIN_MODE, 8'h03);
      repeat (4) begin
         s = $urandom;
         @(posedge pclk);
         interrupt_status <= s;
         chan_a_clock_select <= s[7:4];
         {chan_a_request_to_send, chan_b_request_to_send} <= s[3:2];
         @(negedge pclk);
         chk("status pins", {3'h0, lv(7), lv(6), lv(5), lv(4), lv(1), lv(0)}, {3'h0, ~s[4], ~s[0], ~s[5], ~s[1], s[2], s[3]});
      end
      wr(IDX_PIN_MODE, 8'h00);
      chan_a_clock_select <= CLK_SEL_ONE_X;
      for (int k = 1; k < 4; k++) begin
         wr(IDX_INPUT_ROUTING, {4'h0, k[1:0], k[1:0]});
         repeat (4) begin
            @(posedge pclk);
            chan_a_clock_select <= ~chan_a_clock_select;
            @(negedge pclk);
            c3 = (k == 1) ? 1'h1 : (k == 2) ? uart_clocks.chan_b_tx_clock : uart_clocks.chan_b_rx_clock;
            c2 = (chan_a_clock_select == CLK_SEL_ONE_X) ? uart_clocks.chan_a_tx_clock : uart_clocks.chan_a_tx_clock_16x;
            c2 = (k == 1) ? c2 : (k == 2) ? uart_clocks.chan_a_tx_clock : uart_clocks.chan_a_rx_clock;
            chk("clock pins", {7'h00, lv(3), lv(2)}, {7'h00, c3, c2});
         end
      end
      wr(IDX_INPUT_ROUTING, 8'h04);
      wr(IDX_TIMER_UPPER, 8'h01);
      wr(IDX_TIMER_LOWER, 8'h03);
      xfer(1'h0, IDX_START_SET, 8'h00, 10'h200);
      tick(1);
      xfer(1'h0, IDX_STOP_CLEAR, 8'h00, 10'h200);
      xfer(1'h0, IDX_TIMER_UPPER, 8'h00, 10'h001);
      xfer(1'h0, IDX_TIMER_LOWER, 8'h00, 10'h002);
      wr(IDX_TIMER_UPPER, 8'h00);
      xfer(1'h0, IDX_START_SET, 8'h00, 10'h200);
      tick(2);
      @(negedge pclk);
      chk("before terminal", {7'h00, counter_ready, lv(3)}, 9'h001);
      tick(2);
      @(negedge pclk);
      chk("terminal", {7'h00, counter_ready, lv(3)}, 9'h002);
      wr(IDX_PIN_MODE, 8'h04);
      xfer(1'h0, IDX_STOP_CLEAR, 8'h00, 10'h200);
      @(negedge pclk);
      chk("time-out stop", {7'h00, counter_ready, lv(3)}, 9'h002);
      wr(IDX_PIN_MODE, 8'h00);
      xfer(1'h0, IDX_STOP_CLEAR, 8'h00, 10'h200);
      @(negedge pclk);
      chk("stopped", {7'h00, counter_ready, lv(3)}, 9'h001);
      wr(IDX_PIN_MODE, 8'h08);
      wr(IDX_TIMER_LOWER, 8'h01);
      xfer(1'h0, IDX_START_SET, 8'h00, 10'h200);
      xfer(1'h0, IDX_STOP_CLEAR, 8'h00, 10'h200);
      @(negedge pclk);
      chk("timer stop", {8'h00, counter_ready}, 9'h000);
      tick(4);
      @(negedge pclk);
      chk("timer runs on", {8'h00, counter_ready}, 9'h001);
      results();
   end
endmodule : output_port_and_timer_regs_bench
bind output_port_and_timer_regs port_timer_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pslverr(pslverr),
   .interrupt_status(interrupt_status), .uart_clocks(uart_clocks), .count_tick(count_tick), .pins(pins),
   .counter_ready(counter_ready));

/* File: sim/port_timer_monitor.sv */
// checker: pin routing, latch, error and timer-ready relations at the ports
// assumes a bind onto the block; routing and pin mode shadowed from writes
`timescale 1ns/1ps
module port_timer_monitor
   import port_timer_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pslverr,
   input wire logic [7:0] interrupt_status,
   input wire uart_clocks_s uart_clocks,
   input wire logic count_tick,
   input wire pin_drive_s pins,
   input wire logic counter_ready
);
   logic [6:0] idx;
   logic [7:0] rt_r;
   logic [7:0] pm_r;
   logic wr;
   logic stop;
   assign idx = paddr[8:2];
   assign wr = psel && penable && pwrite && pstrb[0];
   // a tick in the same cycle may set ready again, so leave it out
   assign stop = psel && penable && !pwrite && idx == IDX_STOP_CLEAR && !count_tick;
   ////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rt_r <= ROUTING_RESET;
         pm_r <= 8'h00;
      end else begin
         if (wr && idx == IDX_INPUT_ROUTING) begin
            rt_r <= pwdata[7:0];
         end
         if (wr && idx == IDX_PIN_MODE) begin
            pm_r <= pwdata[7:0];
         end
      end
   end
   ////////////////////////////////////////
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence set_s; wr && idx == IDX_START_SET; endsequence
   sequence clr_s; wr && idx == IDX_STOP_CLEAR; endsequence
   sequence rise_s; !counter_ready ##1 counter_ready; endsequence
   property od_p(en, st, oe, o); en |-> oe == !st && (oe || !o); endproperty
   pin7_status_a: assert property (od_p(rt_r[7], interrupt_status[IS_TX_B], pins.oe_n[7], pins.out[7]))
      else $error("pin 7 status drive wrong");
   pin6_status_a: assert property (od_p(rt_r[6], interrupt_status[IS_TX_A], pins.oe_n[6], pins.out[6]))
      else $error("pin 6 status drive wrong");
   pin5_status_a: assert property (od_p(rt_r[5], interrupt_status[IS_RX_B], pins.oe_n[5], pins.out[5]))
      else $error("pin 5 status drive wrong");
   pin4_status_a: assert property (od_p(rt_r[4], interrupt_status[IS_RX_A], pins.oe_n[4], pins.out[4]))
      else $error("pin 4 status drive wrong");
   set_bits_a: assert property (set_s |=> (pins.out[7:4] & $past(pwdata[7:4]) & ~rt_r[7:4]) == 4'h0)
      else $error("set bit did not pull pin low");
   clear_bits_a: assert property (clr_s |=> (~pins.out[7:4] & $past(pwdata[7:4]) & ~rt_r[7:4]) == 4'h0)
      else $error("clear bit did not raise pin");
   map_error_a: assert property (psel && penable |-> pslverr == !((idx[6:1] == 6'h03) ||
      (idx[6:2] == 5'h03) || (idx[6:2] == 5'h10))) else $error("error flag wrong for index");
   stop_clear_a: assert property (stop && !pm_r[PM_TIMEOUT] |=> !counter_ready)
      else $error("stop left ready set");
   timeout_hold_a: assert property (stop && pm_r[PM_TIMEOUT] && counter_ready |=> counter_ready)
      else $error("stop acted in time-out mode");
   ready_tick_a: assert property (rise_s |-> $past(count_tick))
      else $error("ready rose without a tick");
   pin2_clock_a: assert property (rt_r[1:0] == SEL_THREE |-> !pins.oe_n[2] && pins.out[2] == uart_clocks.chan_a_rx_clock)
      else $error("pin 2 receive clock wrong");
   pin3_clock_a: assert property (rt_r[3:2] == SEL_TWO |-> !pins.oe_n[3] && pins.out[3] == uart_clocks.chan_b_tx_clock)
      else $error("pin 3 transmit clock wrong");
endmodule : port_timer_monitor

/* File: sim/uart_pin_model.sv */
// far side model: the uart clocks that the port block may route to pins
// assumes clocks synchronous to pclk, as the block expects
`timescale 1ns/1ps
module uart_pin_model
   import port_timer_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   output uart_clocks_s uart_clocks
);
   logic [3:0] cnt_r;
   ////////////////////////////////////////
   // 1x clocks run free while idle, so no gating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
      end else begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
   assign uart_clocks = {cnt_r[0], cnt_r[1], cnt_r[2], cnt_r[3], cnt_r[1] ^ cnt_r[3]};
endmodule : uart_pin_model

/* File: src/output_port_and_timer_regs.sv */
// output port latch, pin routing, counter/timer registers, vector and input level registers
// assumes an APB master on pclk; source clock tick and uart clocks arrive synchronous to pclk
//
// Function
// - preset held as upper and lower bytes
// - count readable as upper and lower bytes
// - only counter/timer zero in low map
// - start loads counter from preset
// - stop clears ready bit, captures count
// - read index E starts, F stops
// - time-out mode ignores start and stop
// - vector register is read/write byte
// - input levels bits 6:0, bit7 one
// - pins 0,1 latch bits or request-to-send
// - pin7 latch or inverted tx b status
// - pin6 latch or inverted tx a status
// - pin5 latch or inverted rx b status
// - pin4 latch or inverted rx a status
// - pin3 latch, timer, tx b, rx b clock
// - timer square wave; counter low until stop
// - pin2 latch, 16x, tx 1x, rx 1x clock
// - 16x clock is selected clock, 1x at 1111
// - set register sets latch bits written one
// - clear register clears latch bits written one
// - pins drive inverse of latch bits
// - counter mode ready at terminal count
// - timer ready once per wave, stop no halt
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module output_port_and_timer_regs
   import port_timer_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [6:0] chan_a_port_levels,
   input wire logic [7:0] interrupt_status,
   input wire logic [3:0] chan_a_clock_select,
   input wire logic chan_a_request_to_send,
   input wire logic chan_b_request_to_send,
   input wire uart_clocks_s uart_clocks,
   input wire logic count_tick,
   output pin_drive_s pins,
   output logic counter_ready
);

   ////////////////////////////////////////////////////////////////////////
   // bus decode
   logic setup_rd;
   logic acc_wr;
   logic [6:0] idx;
   logic [7:0] wbyte;
   logic wr_ok;

   function automatic logic hit(input logic [6:0] a, input logic [6:0] target);
      hit = (a == target);
   endfunction : hit

   assign idx = paddr[ADDR_W-1:2];
   assign wbyte = pwdata[7:0];
   assign wr_ok = psel & penable & pwrite & pstrb[0];
   assign acc_wr = wr_ok;
   // commands act once per transfer, at the access edge
   assign setup_rd = psel & penable & ~pwrite;
   assign pready = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [15:0] preset_r;
   logic [15:0] count_r;
   logic [15:0] capture_r;
   logic [7:0] vector_r;
   logic [7:0] routing_r;
   logic [7:0] latch_r;
   logic [7:0] pin_mode_r;
   logic running_r;
   logic wave_r;
   logic terminal_r;
   logic start_cmd;
   logic stop_cmd;
   logic timer_mode;
   logic timeout_mode;
   logic at_zero;
   logic zero_tick;

   assign timer_mode = pin_mode_r[PM_TIMER];
   assign timeout_mode = pin_mode_r[PM_TIMEOUT];
   // only counter/timer zero decodes here
   assign start_cmd = setup_rd & hit(idx, IDX_START_SET) & ~timeout_mode;
   assign stop_cmd = setup_rd & hit(idx, IDX_STOP_CLEAR) & ~timeout_mode;
   assign at_zero = (count_r == 16'h0000);
   // terminal count is the tick that finds the count already at zero,
   // so a preset of n gives n+1 ticks per pass
   assign zero_tick = running_r & count_tick & at_zero;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         preset_r <= PRESET_RESET;
      end else if (acc_wr && hit(idx, IDX_TIMER_UPPER)) begin
         preset_r[15:8] <= wbyte;
      end else if (acc_wr && hit(idx, IDX_TIMER_LOWER)) begin
         preset_r[7:0] <= wbyte;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector_r <= VECTOR_RESET;
      end else if (acc_wr && hit(idx, IDX_VECTOR)) begin
         vector_r <= wbyte;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         routing_r <= ROUTING_RESET;
      end else if (acc_wr && hit(idx, IDX_INPUT_ROUTING)) begin
         routing_r <= wbyte;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_mode_r <= 8'h00;
      end else if (acc_wr && hit(idx, IDX_PIN_MODE)) begin
         pin_mode_r <= wbyte;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_r <= LATCH_RESET;
      end else if (acc_wr && hit(idx, IDX_START_SET)) begin
         latch_r <= latch_r | wbyte;
      end else if (acc_wr && hit(idx, IDX_STOP_CLEAR)) begin
         latch_r <= latch_r & ~wbyte;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counter/timer core
   // both reload from preset at terminal count; counter then stops, timer runs on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= PRESET_RESET;
      end else if (start_cmd) begin
         count_r <= preset_r;
      end else if (stop_cmd && !timer_mode) begin
         // a stop in counter mode freezes the count where it stands
         count_r <= count_r;
      end else if (zero_tick) begin
         count_r <= preset_r;
      end else if (running_r && count_tick) begin
         count_r <= count_r - 16'h0001;
      end
   end

   // timer mode never stops by itself; only counter mode halts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         running_r <= 1'b0;
      end else if (start_cmd) begin
         running_r <= 1'b1;
      end else if (stop_cmd && !timer_mode) begin
         running_r <= 1'b0;
      end else if (zero_tick) begin
         running_r <= timer_mode;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_r <= 16'h0000;
      end else if (stop_cmd) begin
         capture_r <= count_r;
      end
   end

   // wave toggles at every zero, so one full cycle per two zeros
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wave_r <= 1'b1;
      end else if (start_cmd) begin
         wave_r <= 1'b1;
      end else if (timer_mode && zero_tick) begin
         wave_r <= ~wave_r;
      end
   end

   // counter-mode pin: low from terminal count until stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         terminal_r <= 1'b0;
      end else if (!timer_mode && zero_tick) begin
         terminal_r <= 1'b1;
      end else if (stop_cmd) begin
         terminal_r <= 1'b0;
      end
   end

   // set wins over a stop in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_ready <= 1'b0;
      end else if (zero_tick && (!timer_mode || !wave_r)) begin
         counter_ready <= 1'b1;
      end else if (stop_cmd) begin
         counter_ready <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data
   logic [7:0] rbyte;
   logic known;

   always_comb begin
      rbyte = UNMAPPED_DATA;
      known = 1'b1;
      case (idx)
         // value halves come from the capture latch, not the live count
         IDX_TIMER_UPPER: begin
            rbyte = capture_r[15:8];
         end
         IDX_TIMER_LOWER: begin
            rbyte = capture_r[7:0];
         end
         IDX_VECTOR: begin
            rbyte = vector_r;
         end
         IDX_INPUT_ROUTING: begin
            rbyte = {1'b1, chan_a_port_levels};
         end
         // command reads carry no data
         IDX_START_SET: begin
            rbyte = UNMAPPED_DATA;
         end
         IDX_STOP_CLEAR: begin
            rbyte = UNMAPPED_DATA;
         end
         // own readback of write-only state
         IDX_TIMER_MODE: begin
            rbyte = routing_r;
         end
         IDX_LATCH_READ: begin
            rbyte = latch_r;
         end
         IDX_STATUS: begin
            rbyte = {6'h00, counter_ready, running_r};
         end
         IDX_PIN_MODE: begin
            rbyte = pin_mode_r;
         end
         default: begin
            known = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {24'h000000, rbyte};
      end
   end

   assign pslverr = psel & penable & ~known;

   ////////////////////////////////////////////////////////////////////////
   // pin routing; oe_n low means driven, high means released
   logic [7:0] pin_val;
   logic [7:0] pin_oe_n;
   logic clk16;
   route_sel_e sel3;
   route_sel_e sel2;

   assign sel3 = route_sel_e'(routing_r[RT_IO3_LO +: 2]);
   assign sel2 = route_sel_e'(routing_r[RT_IO2_LO +: 2]);
   assign clk16 = (chan_a_clock_select == CLK_SEL_ONE_X) ? uart_clocks.chan_a_tx_clock
                                                          : uart_clocks.chan_a_tx_clock_16x;

   always_comb begin
      pin_val = ~latch_r;
      pin_oe_n = 8'h00;
      if (pin_mode_r[PM_RTS_A]) begin
         pin_val[0] = chan_a_request_to_send;
      end
      if (pin_mode_r[PM_RTS_B]) begin
         pin_val[1] = chan_b_request_to_send;
      end
      // clocks pass straight through; they are not retimed to pclk
      case (sel2)
         SEL_ONE: begin
            pin_val[2] = clk16;
         end
         SEL_TWO: begin
            pin_val[2] = uart_clocks.chan_a_tx_clock;
         end
         SEL_THREE: begin
            pin_val[2] = uart_clocks.chan_a_rx_clock;
         end
         default: begin
            pin_val[2] = ~latch_r[2];
         end
      endcase
      case (sel3)
         // open drain: released means high, driven means low
         SEL_ONE: begin
            pin_val[3] = 1'b0;
            pin_oe_n[3] = timer_mode ? wave_r : ~terminal_r;
         end
         SEL_TWO: begin
            pin_val[3] = uart_clocks.chan_b_tx_clock;
         end
         SEL_THREE: begin
            pin_val[3] = uart_clocks.chan_b_rx_clock;
         end
         default: begin
            pin_val[3] = ~latch_r[3];
         end
      endcase
      // open drain: drive low while status set, release otherwise
      if (routing_r[4]) begin
         pin_val[4] = 1'b0;
         pin_oe_n[4] = ~interrupt_status[IS_RX_A];
      end
      if (routing_r[5]) begin
         pin_val[5] = 1'b0;
         pin_oe_n[5] = ~interrupt_status[IS_RX_B];
      end
      if (routing_r[6]) begin
         pin_val[6] = 1'b0;
         pin_oe_n[6] = ~interrupt_status[IS_TX_A];
      end
      if (routing_r[7]) begin
         pin_val[7] = 1'b0;
         pin_oe_n[7] = ~interrupt_status[IS_TX_B];
      end
   end

   assign pins.out = pin_val;
   assign pins.oe_n = pin_oe_n;

endmodule : output_port_and_timer_regs
